// ### hdl/ssfmd_fifo.sv
// Small valid/ready FIFO for regenerated samples
`timescale 1ns/1ps
`default_nettype none
module ssfmd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];        // Storage
  logic [AW-1:0] wp_q;           // Write pointer
  logic [AW-1:0] rp_q;           // Read pointer
  logic [AW:0]   cnt_q;          // Fill level
  logic          wr;
  logic          rd;
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;
  assign out_data  = mem[rp_q];
  // Memory write, no reset needed on data
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_q] <= in_data;
    end
  end
  // Pointers and level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + AW'(1);
      if (rd) rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule
`default_nettype wire

// ### hdl/ssfmd_map.svh
// Constants for the start-stop framing and mode detector
`ifndef SSFMD_MAP_SVH
`define SSFMD_MAP_SVH
`define SSFMD_TICKS_PER_BIT  8'd128
`define SSFMD_HALF_BIT       7'd64
`define SSFMD_QUARTER_BIT    7'd32
`define SSFMD_WIN_HI         7'd96
`define SSFMD_STOP_5         4'h6
`define SSFMD_STOP_7         4'h8
`define SSFMD_STOP_8         4'h9
`define SSFMD_LONG_MARK_MS   1000
`define SSFMD_LOWSENS_MS     200
`define SSFMD_CLK_HZ         20000000
`define SSFMD_LONG_MARK_CYC  ((`SSFMD_CLK_HZ / 1000) * `SSFMD_LONG_MARK_MS)
`define SSFMD_LOWSENS_CYC    ((`SSFMD_CLK_HZ / 1000) * `SSFMD_LOWSENS_MS)
`define SSFMD_MODE_SS        1'b0
`define SSFMD_MODE_SYNC      1'b1
`endif

// ### hdl/ssfmd_pkg.sv
// Types for the start-stop framing and mode detector
package ssfmd_pkg;
  typedef enum logic [1:0] {
    SSFMD_CODE_5 = 2'b00,
    SSFMD_CODE_7 = 2'b01,
    SSFMD_CODE_8 = 2'b10
  } ssfmd_code_t;
  typedef enum logic [1:0] {
    SSFMD_ST_REST  = 2'b00,
    SSFMD_ST_QUAL  = 2'b01,
    SSFMD_ST_COUNT = 2'b10
  } ssfmd_state_t;
  typedef struct packed {
    logic        manual;
    logic        manual_mode;
    logic        mark_hold;
    logic        low_sens;
    ssfmd_code_t code;
  } ssfmd_cfg_t;
  typedef struct packed {
    logic       mode_sync;
    logic       stop_int;
    logic [3:0] bits;
  } ssfmd_stat_t;
endpackage

// ### hdl/ssfmd_top.sv
// Start-stop character framing and automatic mode decision
// Behaviour
// - Start edge in stop interval zeroes bit timer
// - Set false-start flag; sample half bit later
// - Mark at half bit suppresses counter reset
// - Four-stage counter counts character bit intervals
// - Five, seven and eight level lengths
// - Stop counting after stop point; re-arm
// - Mark-hold forces output Mark in stop, start-stop mode only
// - Mark-hold is static; off follows line
// - Space at framing pulse selects synchronous
// - Edge outside quarter-bit window selects start-stop
// - Low sensitivity needs two edges 200 ms apart
// - One second steady Mark forces start-stop
// - Mark in successive rests selects start-stop
// - Manual mode holds operator-chosen flag
// - Manual mode disables long-Mark detector
// - 128 ticks per bit give sample points
`timescale 1ns/1ps
`default_nettype none
`include "ssfmd_map.svh"
module ssfmd_top #(
  parameter int LONG_MARK_CYC = `SSFMD_LONG_MARK_CYC,
  parameter int LOWSENS_CYC   = `SSFMD_LOWSENS_CYC,
  parameter int FIFO_DEPTH    = 8
) (
  input  wire logic                CLK,
  input  wire logic                NRST,
  input  wire logic                LINE_IN,
  input  wire logic                TICK,
  input  wire ssfmd_pkg::ssfmd_cfg_t CFG,
  output logic                     REGEN_VALID,
  input  wire logic                REGEN_READY,
  output logic                     REGEN_DATA,
  output ssfmd_pkg::ssfmd_stat_t   STATUS,
  output logic                     OVERRUN
);
  // Line (1 = Mark) and tick come from outside: two-flop sync
  logic [1:0] line_s_q;            // Line synchroniser
  logic [1:0] tick_s_q;            // Tick synchroniser
  logic       line_q;              // Line one stage later for edges
  logic       tick_q;              // Tick one stage later for edges
  logic       ms_edge;             // Mark-to-space transition
  logic       tk;                  // One tick of local timing
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      line_s_q <= 2'h3;
      tick_s_q <= 2'h0;
      line_q   <= 1'b1;
      tick_q   <= 1'b0;
    end else begin
      line_s_q <= {line_s_q[0], LINE_IN};
      tick_s_q <= {tick_s_q[0], TICK};
      line_q   <= line_s_q[1];
      tick_q   <= tick_s_q[1];
    end
  end
  assign ms_edge = line_q && !line_s_q[1];
  assign tk      = tick_s_q[1] && !tick_q;

  // Framing state and counters
  ssfmd_pkg::ssfmd_state_t st_q;   // Character framing state
  logic [6:0] phase_q;             // Tick count inside a bit
  logic [3:0] bits_q;              // Character bit counter
  logic       fstart_q;            // False-start flag
  logic       mode_q;              // Mode flag, 1 = synchronous
  logic [3:0] stop_pt;             // Bit count where stop interval opens
  logic       half_pt;             // Half-bit sample point
  logic       frame_pls;           // End-of-character framing pulse
  logic       stop_int;            // Stop-Mark interval
  always_comb begin
    unique case (CFG.code)
      ssfmd_pkg::SSFMD_CODE_7: stop_pt = `SSFMD_STOP_7;
      ssfmd_pkg::SSFMD_CODE_8: stop_pt = `SSFMD_STOP_8;
      default:                 stop_pt = `SSFMD_STOP_5;
    endcase
  end
  assign half_pt   = tk && (phase_q == `SSFMD_HALF_BIT - 7'd1);
  // Stop point sits half a bit into the stop element
  // The count steps on this same pulse, so compare one short:
  // five-level code then ends six and a half bits after start
  // and the counter rests at the stop count while idle
  assign frame_pls = (st_q == ssfmd_pkg::SSFMD_ST_COUNT) && half_pt
                     && (bits_q == stop_pt - 4'h1);
  assign stop_int  = (st_q != ssfmd_pkg::SSFMD_ST_COUNT);

  // Bit timer: zeroed by a start edge, else free on ticks
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      phase_q <= 7'h00;
    end else if (st_q == ssfmd_pkg::SSFMD_ST_REST && ms_edge) begin
      phase_q <= 7'h00;
    end else if (tk) begin
      phase_q <= phase_q + 7'h01;
    end
  end

  // Framing state machine
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q     <= ssfmd_pkg::SSFMD_ST_REST;
      fstart_q <= 1'b0;
    end else begin
      unique case (st_q)
        ssfmd_pkg::SSFMD_ST_REST: begin
          if (ms_edge) begin
            st_q     <= ssfmd_pkg::SSFMD_ST_QUAL;
            fstart_q <= 1'b1;
          end
        end
        ssfmd_pkg::SSFMD_ST_QUAL: begin
          if (half_pt) begin
            fstart_q <= 1'b0;
            // Mark here is noise: go back without counting
            st_q <= line_s_q[1] ? ssfmd_pkg::SSFMD_ST_REST
                                : ssfmd_pkg::SSFMD_ST_COUNT;
          end
        end
        ssfmd_pkg::SSFMD_ST_COUNT: begin
          if (frame_pls) begin
            st_q <= ssfmd_pkg::SSFMD_ST_REST;
          end
        end
        default: st_q <= ssfmd_pkg::SSFMD_ST_REST;
      endcase
    end
  end

  // Character bit counter: cleared by a valid start, stepped per bit
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bits_q <= 4'h0;
    end else if (st_q == ssfmd_pkg::SSFMD_ST_QUAL && half_pt
                 && !line_s_q[1]) begin
      bits_q <= 4'h0;
    end else if (st_q == ssfmd_pkg::SSFMD_ST_COUNT && half_pt) begin
      bits_q <= bits_q + 4'h1;
    end
  end

  // Phase window around the timing phasing edge (phase 0)
  logic in_window;                 // Quarter bit either side
  logic oow_edge;                  // Out-of-window start edge
  assign in_window = (phase_q < `SSFMD_QUARTER_BIT)
                     || (phase_q >= `SSFMD_WIN_HI);
  assign oow_edge  = mode_q && ms_edge && !in_window;

  // Low sensitivity: second out-of-window edge after about 200 ms
  logic [31:0] ls_cnt_q;           // Time since first bad edge
  logic        ls_arm_q;           // First bad edge seen
  logic        ls_ok;              // Spacing reached
  assign ls_ok = (ls_cnt_q >= 32'(LOWSENS_CYC));
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ls_arm_q <= 1'b0;
      ls_cnt_q <= 32'h0;
    end else if (!mode_q) begin
      ls_arm_q <= 1'b0;
      ls_cnt_q <= 32'h0;
    end else if (oow_edge && !ls_arm_q) begin
      ls_arm_q <= 1'b1;
      ls_cnt_q <= 32'h0;
    end else if (ls_arm_q && !ls_ok) begin
      ls_cnt_q <= ls_cnt_q + 32'h1;
    end
  end

  // Long-Mark timer, restarted by any line Space
  logic [31:0] lm_cnt_q;           // Steady Mark duration
  logic        long_mark;          // Timer ran out
  assign long_mark = (lm_cnt_q >= 32'(LONG_MARK_CYC)) && !CFG.manual;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lm_cnt_q <= 32'h0;
    end else if (!line_s_q[1] || CFG.manual) begin
      lm_cnt_q <= 32'h0;
    end else if (lm_cnt_q < 32'(LONG_MARK_CYC)) begin
      lm_cnt_q <= lm_cnt_q + 32'h1;
    end
  end

  // Rest-Mark detector: Mark at consecutive framing pulses in sync
  logic rest_mark_q;               // Previous rest interval held Mark
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rest_mark_q <= 1'b0;
    end else if (!mode_q) begin
      rest_mark_q <= 1'b0;
    end else if (frame_pls) begin
      rest_mark_q <= line_s_q[1];
    end
  end

  // Mode decision flag; manual wins over every detector
  logic to_ss;                     // Any start-stop indication
  assign to_ss = long_mark
               || (mode_q && frame_pls && line_s_q[1]
                   && rest_mark_q)
               || (oow_edge && (!CFG.low_sens
                   || (ls_arm_q && ls_ok)));
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mode_q <= `SSFMD_MODE_SS;
    end else if (CFG.manual) begin
      mode_q <= CFG.manual_mode;
    end else if (to_ss) begin
      mode_q <= `SSFMD_MODE_SS;
    end else if (!mode_q && frame_pls && !line_s_q[1]) begin
      mode_q <= `SSFMD_MODE_SYNC;
    end
  end

  // Regenerated sample per bit; Mark-hold clamps the stop interval in start-stop mode
  logic regen_bit;                 // Output level this tick
  logic fifo_ready;                // FIFO accepts
  logic ovr_q;                     // Sticky sample loss
  assign regen_bit = line_s_q[1]
                   || (CFG.mark_hold && !mode_q && stop_int);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ovr_q <= 1'b0;
    end else if (half_pt && !fifo_ready) begin
      ovr_q <= 1'b1;
    end
  end
  // Sampled once per bit at mid-bit; loss is flagged, not stalled,
  // because the line cannot be held off
  ssfmd_fifo #(.W(1), .D(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (half_pt),
    .in_ready  (fifo_ready),
    .in_data   (regen_bit),
    .out_valid (REGEN_VALID),
    .out_ready (REGEN_READY),
    .out_data  (REGEN_DATA)
  );
  assign OVERRUN         = ovr_q;
  assign STATUS.mode_sync = mode_q;
  assign STATUS.stop_int  = stop_int;
  assign STATUS.bits      = bits_q;

  // Checks
  chk_false_reset: assert property (@(posedge CLK) disable iff (!NRST)
    (st_q == ssfmd_pkg::SSFMD_ST_QUAL && half_pt && line_s_q[1])
      |=> st_q == ssfmd_pkg::SSFMD_ST_REST)
    else $error("false start not rejected");
  chk_manual_hold: assert property (@(posedge CLK) disable iff (!NRST)
    CFG.manual |=> mode_q == $past(CFG.manual_mode))
    else $error("manual mode not held");
  chk_mark_hold: assert property (@(posedge CLK) disable iff (!NRST)
    (CFG.mark_hold && !mode_q && stop_int) |-> regen_bit)
    else $error("mark hold failed");
  chk_start_zero: assert property (@(posedge CLK) disable iff (!NRST)
    (st_q == ssfmd_pkg::SSFMD_ST_REST && ms_edge)
      |=> phase_q == 7'h00 && fstart_q)
    else $error("start did not zero timer");

  // Space at the half-bit sample: a true start
  sequence seq_good_start;
    st_q == ssfmd_pkg::SSFMD_ST_QUAL && half_pt && !line_s_q[1];
  endsequence
  // True start clears the counter and begins counting
  chk_count_clear: assert property (@(posedge CLK) disable iff (!NRST)
    seq_good_start
      |=> bits_q == 4'h0 && st_q == ssfmd_pkg::SSFMD_ST_COUNT)
    else $error("valid start did not clear counter");
  // Framing pulse re-arms and leaves the stop count
  chk_frame_end: assert property (@(posedge CLK) disable iff (!NRST)
    frame_pls
      |=> st_q == ssfmd_pkg::SSFMD_ST_REST && bits_q == stop_pt)
    else $error("framing pulse did not re-arm");
  // Space in the stop interval means synchronous traffic
  chk_sync_space: assert property (@(posedge CLK) disable iff (!NRST)
    (!CFG.manual && !to_ss && !mode_q && frame_pls
     && !line_s_q[1]) |=> mode_q)
    else $error("space in stop did not select sync");
  // Steady Mark beyond the limit forces start-stop
  chk_long_mark: assert property (@(posedge CLK) disable iff (!NRST)
    long_mark |=> !mode_q)
    else $error("long mark did not force start-stop");
  // One bad edge is enough at normal sensitivity
  chk_bad_edge: assert property (@(posedge CLK) disable iff (!NRST)
    (!CFG.manual && !CFG.low_sens && oow_edge) |=> !mode_q)
    else $error("edge outside window ignored");
  // Manual mode keeps the long-Mark timer cleared
  chk_lm_manual: assert property (@(posedge CLK) disable iff (!NRST)
    CFG.manual |=> lm_cnt_q == 32'h0)
    else $error("long mark timer ran in manual");
  // Overrun stays set until reset, so a loss is never missed
  chk_ovr_sticky: assert property (@(posedge CLK) disable iff (!NRST)
    ovr_q |=> ovr_q)
    else $error("overrun flag dropped");
endmodule
`default_nettype wire

// ### tb/ssfmd_line.sv
// Far-side model: telegraph line and free-running bit-timing ticks
`timescale 1ns/1ps
`default_nettype none
module ssfmd_line (
  input  wire logic clk,
  output logic      line,
  output logic      tick
);
  logic [2:0] div_q = 3'h0; // Six clocks per tick
  int         ph = 0;       // Tick phase within the bit
  int         n_tick = 0;   // Ticks since time zero
  initial line = 1'b1;
  initial tick = 1'b0;
  // Ticks 3 clocks high and 3 low, 128 to a bit
  always @(posedge clk) begin
    div_q <= (div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
    tick  <= (div_q < 3'h3);
    if (div_q == 3'h0) begin
      ph     <= (ph + 1) % 128;
      n_tick <= n_tick + 1;
    end
  end
  // Edge that opens phase p; always moves on at least one clock
  task automatic at_ph(input int p);
    do @(posedge clk); while (ph != p || div_q != 3'h0);
  endtask
  // Space pulse of w ticks starting at phase p
  task automatic pulse(input int p, input int w);
    at_ph(p);
    line <= 1'b0;
    at_ph((p + w) % 128);
    line <= 1'b1;
  endtask
  // Start, n data bits, two bits at stop level, then Mark
  task automatic chr(input logic [7:0] d, input int n, input logic sb);
    at_ph(0);
    line <= 1'b0;
    for (int i = 0; i < n; i++) begin
      at_ph(0);
      line <= d[i];
    end
    at_ph(0);
    line <= sb;
    at_ph(0);
    at_ph(0);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### tb/ssfmd_top_bench.sv
// Self-checking bench for the framing and mode detector
`timescale 1ns/1ps
`default_nettype none
`include "ssfmd_map.svh"
module ssfmd_top_bench;
  localparam int LM  = 6000;                 // Short long-Mark count
  localparam int LS  = 2000;                 // Short low-sens spacing
  localparam int TPB = `SSFMD_TICKS_PER_BIT; // Ticks per bit
  localparam int HB  = `SSFMD_HALF_BIT;      // Half-bit ticks
  logic                   clk = 1'b0;        // 20 MHz clock
  logic                   nrst = 1'b0;       // Reset, active low
  logic                   line;              // Line level
  logic                   tick;              // Bit-timing tick
  ssfmd_pkg::ssfmd_cfg_t  cfg = '0;          // Static options
  logic                   rdy = 1'b1;        // Sample drain
  logic                   rvalid;            // Sample waiting
  logic                   rdata;             // Sample value
  ssfmd_pkg::ssfmd_stat_t stat;              // Mode and framing
  logic                   ovr;               // Sticky overflow
  logic                   hold = 1'b0;       // Stall the drain
  logic                   rnd = 1'b0;        // Random drain
  logic [31:0]            rs = 32'h1FAC5B21; // Drain pattern
  logic [31:0]            seed = 32'h1FAC5B21; // Data pattern
  logic                   q[$];              // Drained samples
  int                     el;                // Start to frame end
  int                     n_fail = 0;
  int                     comparisons = 0;
  always #25 clk = ~clk;
  ssfmd_line ln (.clk(clk), .line(line), .tick(tick));
  ssfmd_top #(.LONG_MARK_CYC(LM), .LOWSENS_CYC(LS), .FIFO_DEPTH(8)) dut (
    .CLK(clk), .NRST(nrst), .LINE_IN(line), .TICK(tick), .CFG(cfg),
    .REGEN_VALID(rvalid), .REGEN_READY(rdy), .REGEN_DATA(rdata),
    .STATUS(stat), .OVERRUN(ovr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Count held after the framing pulse for code index i
  function automatic logic [3:0] stopc(input int i);
    return i == 0 ? `SSFMD_STOP_5 : i == 1 ? `SSFMD_STOP_7 : `SSFMD_STOP_8;
  endfunction
  // Framing pulse falls half a bit after the last counted bit
  function automatic int exp_el(input int i);
    return TPB * int'(stopc(i)) + HB;
  endfunction
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Options change only under reset, since they are static
  task automatic rst(input ssfmd_pkg::ssfmd_cfg_t c);
    @(posedge clk);
    nrst <= 1'b0;
    cfg  <= c;
    repeat (4) @(posedge clk);
    ln.at_ph(0);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(stat.mode_sync === (c.manual & c.manual_mode), "mode");
    chk(stat.stop_int === 1'b1 && ovr === 1'b0, "idle");
  endtask
  // Send one character and time it from start edge to frame end
  task automatic frame(input int n, input logic sb, input logic [7:0] d);
    int t0;
    int k;
    fork
      ln.chr(d, n, sb);
      begin
        @(negedge line);
        t0 = ln.n_tick;
        q.delete();
        k = 0;
        while (stat.stop_int !== 1'b0 && k < 2000) begin
          @(posedge clk);
          k++;
        end
        while (stat.stop_int !== 1'b1 && k < 12000) begin
          @(posedge clk);
          k++;
        end
        el = ln.n_tick - t0;
      end
    join
  endtask
  // Drain: stalled, random or always ready
  always @(posedge clk) begin
    rs  <= lfsr(rs);
    rdy <= hold ? 1'b0 : (rnd ? rs[0] : 1'b1);
  end
  // Keep every sample handed over
  always @(posedge clk)
    if (rvalid === 1'b1 && rdy === 1'b1) q.push_back(rdata);
  // Watchdog of 100000 cycles, above the expected run of about 97k cycles
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    int n;
    int e;
    logic [7:0] d;
    // Each code once, Mark-hold on for the 7-level case only
    for (int i = 0; i < 3; i++) begin
      rst({2'b00, i[0], 1'b0, i[1:0]});
      n = (i == 2) ? 8 : 5 + 2 * i;
      d = seed[7:0];
      seed = lfsr(seed);
      frame(n, 1'b1, d);
      e = exp_el(i);
      chk(el >= e - 4 && el <= e + 4, "frame length");
      chk(stat.bits === stopc(i), "count at end");
      chk(q[0] === i[0], "start sample");
      for (int k = 0; k < n; k++) chk(q[k + 1] === d[k], "data");
    end
    $display("code tests done");
    rst('0);
    frame(5, 1'b0, 8'h15);
    chk(stat.mode_sync === 1'b1, "space in stop");
    frame(5, 1'b1, 8'h15);
    chk(stat.mode_sync === 1'b1, "one rest mark");
    frame(5, 1'b1, 8'h15);
    chk(stat.mode_sync === 1'b0, "two rest marks");
    frame(5, 1'b0, 8'h15);
    ln.pulse(64, 16);
    repeat (300) @(posedge clk);
    chk(stat.mode_sync === 1'b0, "outside window");
    repeat (700) @(posedge clk);
    chk(stat.bits === `SSFMD_STOP_5, "false start");
    frame(5, 1'b0, 8'h15);
    repeat (LM - 1500) @(posedge clk);
    chk(stat.mode_sync === 1'b1, "short mark");
    repeat (3000) @(posedge clk);
    chk(stat.mode_sync === 1'b0, "long mark");
    $display("mode tests done");
    rst(6'b000100);
    frame(5, 1'b0, 8'h15);
    ln.pulse(64, 16);
    repeat (300) @(posedge clk);
    chk(stat.mode_sync === 1'b1, "one bad edge");
    repeat (LS) @(posedge clk);
    ln.pulse(0, 16);
    repeat (300) @(posedge clk);
    chk(stat.mode_sync === 1'b0, "second bad edge");
    $display("low sensitivity test done");
    rst(6'b110000);
    hold <= 1'b1;
    repeat (LM + 2000) @(posedge clk);
    chk(stat.mode_sync === 1'b1, "manual sync");
    chk(ovr === 1'b1 && rvalid === 1'b1, "full buffer");
    ln.at_ph(80);
    q.delete();
    hold <= 1'b0;
    rnd  <= 1'b1;
    repeat (60) @(posedge clk);
    chk(q.size() == 8 && rvalid === 1'b0, "buffer drained");
    rnd <= 1'b0;
    rst(6'b100000);
    frame(5, 1'b0, 8'h15);
    chk(stat.mode_sync === 1'b0, "manual start-stop");
    $display("manual and buffer tests done");
    test_done();
  end
endmodule
`default_nettype wire
